// ---- rtl/cbu_pkg.sv ----
// Purpose: Shared constants and types for the conditional branch unit
// Assumes: 16-bit word program counter, 7-bit signed branch offset
// Notes: Register offsets for the Avalon-MM slave live here too
package cbu_pkg;
    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PC_W = 16;
    localparam int OFS_W = 7;
    localparam int SEL_W = 4;

    // ----------------------------------------------------------------
    // Status flag bit positions in the flag byte
    // ----------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;

    // ----------------------------------------------------------------
    // Register map (byte addresses, word aligned)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PC = 4'h4;
    localparam logic [3:0] ADDR_FLAGS = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hC;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_TAKEN_BIT = 1;
    localparam int STAT_CNT_LSB = 8;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic CTRL_EN_RESET = 1'b1;

    // ----------------------------------------------------------------
    // Timing counts in core cycles
    // ----------------------------------------------------------------
    localparam int CYC_NOT_TAKEN = 1;
    localparam int CYC_TAKEN = 2;

    // Branch conditions selectable by the decoder
    typedef enum logic [SEL_W-1:0] {
        branch_on_carry_clear,
        branch_on_same_or_higher,
        branch_on_lower_unsigned,
        branch_on_negative,
        branch_on_positive,
        branch_on_signed_ge,
        branch_on_signed_lt,
        branch_on_half_carry_set,
        branch_on_half_carry_clear,
        branch_on_transfer_bit_set
    } cbu_cond_t;

    typedef enum logic [0:0] {
        CBU_IDLE,
        CBU_SECOND
    } cbu_state_t;
endpackage

// ---- rtl/cbu_cond_eval.sv ----
// Purpose: Decides whether a conditional branch is taken
// Assumes: Flags stable for the cycle the branch is issued
// Notes: Purely combinational
module cbu_cond_eval
    import cbu_pkg::*;
(
    input wire logic [SEL_W-1:0] sel,
    input wire logic [7:0] flags,
    output logic taken
);
    // ----------------------------------------------------------------
    // Condition mux
    // ----------------------------------------------------------------
    // Signed compare uses N xor V so overflowed results still order right
    always_comb begin
        taken = 1'b0;
        case (cbu_cond_t'(sel))
            branch_on_carry_clear: taken = (flags[FLAG_C] == 1'b0);
            branch_on_same_or_higher: taken = (flags[FLAG_C] == 1'b0);
            branch_on_lower_unsigned: taken = (flags[FLAG_C] == 1'b1);
            branch_on_negative: taken = (flags[FLAG_N] == 1'b1);
            branch_on_positive: taken = (flags[FLAG_N] == 1'b0);
            branch_on_signed_ge: taken = ((flags[FLAG_N] ^ flags[FLAG_V]) == 1'b0);
            branch_on_signed_lt: taken = ((flags[FLAG_N] ^ flags[FLAG_V]) == 1'b1);
            branch_on_half_carry_set: taken = (flags[FLAG_H] == 1'b1);
            branch_on_half_carry_clear: taken = (flags[FLAG_H] == 1'b0);
            branch_on_transfer_bit_set: taken = (flags[FLAG_T] == 1'b1);
            default: taken = 1'b0;
        endcase
    end
endmodule // cbu_cond_eval

// ---- rtl/cbu_target.sv ----
// Purpose: Computes the relative branch target and the fall-through address
// Assumes: Offset is a signed two's-complement word displacement
// Notes: Wraps modulo the program counter width
module cbu_target
    import cbu_pkg::*;
(
    input wire logic [PC_W-1:0] pc,
    input wire logic [OFS_W-1:0] offset,
    output logic [PC_W-1:0] target,
    output logic [PC_W-1:0] next_seq
);
    // Sign-extend the displacement to the counter width
    function automatic logic [PC_W-1:0] sext(input logic [OFS_W-1:0] k);
        sext = {{(PC_W-OFS_W){k[OFS_W-1]}}, k};
    endfunction

    // ----------------------------------------------------------------
    // Address arithmetic
    // ----------------------------------------------------------------
    assign target = pc + sext(offset) + 16'h0001;
    assign next_seq = pc + 16'h0001;
endmodule // cbu_target

// ---- rtl/cbu_branch_unit.sv ----
// Purpose: Conditional relative-branch unit with Avalon-MM register access
// Assumes: CLK 20 MHz, RESET_N asynchronous active low, CE freezes state
// Notes: Branches issue from the decoder port; software may observe and
//        preset the program counter and flags through the register slave
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
module cbu_branch_unit
    import cbu_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic BR_VALID,
    input wire logic [SEL_W-1:0] BR_COND,
    input wire logic [OFS_W-1:0] BR_OFFSET,
    output logic BR_READY,
    output logic BR_DONE,
    output logic BR_TAKEN,
    output logic [PC_W-1:0] PC,
    output logic [7:0] FLAGS,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    cbu_state_t state;
    logic enable;
    logic taken;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] next_seq;
    logic [PC_W-1:0] pend_target;
    logic [15:0] taken_cnt;
    logic rd_done;
    logic issue;
    logic sw_pc_wr;
    logic sw_flag_wr;
    logic wr_commit;
    logic [31:0] stat_word;

    // Merge byte lanes of a write into an existing value
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = old;
        if (be[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (be[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    cbu_cond_eval u_cond (
        .sel(BR_COND),
        .flags(FLAGS),
        .taken(taken)
    );

    cbu_target u_target (
        .pc(PC),
        .offset(BR_OFFSET),
        .target(target),
        .next_seq(next_seq)
    );

    // ----------------------------------------------------------------
    // Branch sequencing
    // ----------------------------------------------------------------
    // A new branch is accepted only in the idle state, so the second cycle
    // of a taken branch back-pressures the decoder
    assign BR_READY = enable && (state == CBU_IDLE);
    assign issue = CE && BR_VALID && BR_READY;

    // State: a taken branch spends one extra cycle refilling
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= CBU_IDLE;
        end else if (CE) begin
            case (state)
                CBU_IDLE: begin
                    if (issue && taken) begin
                        state <= CBU_SECOND;
                    end
                end
                CBU_SECOND: begin
                    state <= CBU_IDLE;
                end
                default: begin
                    state <= CBU_IDLE;
                end
            endcase
        end
    end

    // Latch the target so the PC moves at the end of the second cycle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pend_target <= PC_RESET;
        end else if (CE && issue && taken) begin
            pend_target <= target;
        end
    end

    // Completion pulse and outcome
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            BR_DONE <= 1'b0;
            BR_TAKEN <= 1'b0;
        end else if (CE) begin
            BR_DONE <= (issue && !taken) || (state == CBU_SECOND);
            if (issue) begin
                BR_TAKEN <= taken;
            end
        end
    end

    // ----------------------------------------------------------------
    // Program counter
    // ----------------------------------------------------------------
    // Software writes lose to a branch in flight so the sequence stays whole
    assign sw_pc_wr = wr_commit && (AVS_ADDRESS == ADDR_PC);
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PC <= PC_RESET;
        end else if (CE) begin
            if (state == CBU_SECOND) begin
                PC <= pend_target;
            end else if (issue && !taken) begin
                PC <= next_seq;
            end else if (sw_pc_wr && !issue) begin
                PC <= merge16(PC, AVS_WRITEDATA, AVS_BYTEENABLE);
            end
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    // Only software changes the flags; branches never touch them
    assign sw_flag_wr = wr_commit && (AVS_ADDRESS == ADDR_FLAGS);
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FLAGS <= FLAGS_RESET;
        end else if (CE && sw_flag_wr && AVS_BYTEENABLE[0]) begin
            FLAGS <= AVS_WRITEDATA[7:0];
        end
    end

    // Count taken branches for software visibility
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            taken_cnt <= 16'h0000;
        end else if (CE && issue && taken) begin
            taken_cnt <= taken_cnt + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            enable <= CTRL_EN_RESET;
        end else if (CE && wr_commit && (AVS_ADDRESS == ADDR_CTRL)
                     && AVS_BYTEENABLE[0]) begin
            enable <= AVS_WRITEDATA[CTRL_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave
    // ----------------------------------------------------------------
    // Every access takes two cycles: waitrequest high on the first, low on
    // the second; rd_done marks the second so a held request is taken once
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rd_done <= 1'b0;
        end else if (CE) begin
            rd_done <= (AVS_READ || AVS_WRITE) && !rd_done;
        end
    end
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !rd_done;
    // Writes land only on the edge that sees waitrequest low, as the master expects
    assign wr_commit = AVS_WRITE && rd_done;

    // Status word laid out by the package field positions
    always_comb begin
        stat_word = 32'h00000000;
        stat_word[STAT_BUSY_BIT] = (state == CBU_SECOND);
        stat_word[STAT_TAKEN_BIT] = BR_TAKEN;
        stat_word[STAT_CNT_LSB +: 16] = taken_cnt;
    end

    // Read data register; unmapped addresses read zero
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            AVS_READDATA <= 32'h00000000;
        end else if (CE && AVS_READ && !rd_done) begin
            if (AVS_ADDRESS == ADDR_CTRL) begin
                AVS_READDATA <= {31'h0, enable};
            end else if (AVS_ADDRESS == ADDR_PC) begin
                AVS_READDATA <= {16'h0000, PC};
            end else if (AVS_ADDRESS == ADDR_FLAGS) begin
                AVS_READDATA <= {24'h000000, FLAGS};
            end else if (AVS_ADDRESS == ADDR_STAT) begin
                AVS_READDATA <= stat_word;
            end else begin
                AVS_READDATA <= 32'h00000000;
            end
        end
    end
endmodule // cbu_branch_unit

// ---- dv/cbu_assertions.sv ----
// Purpose: Port checks for the conditional branch unit
// Assumes: CE stays high while a branch is in flight
// Notes: Own condition decode, kept apart from the design
module cbu_assertions
    import cbu_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic BR_VALID,
    input wire logic [SEL_W-1:0] BR_COND,
    input wire logic [OFS_W-1:0] BR_OFFSET,
    input wire logic BR_READY,
    input wire logic BR_DONE,
    input wire logic BR_TAKEN,
    input wire logic [PC_W-1:0] PC,
    input wire logic [7:0] FLAGS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST
);
    // ----------------------------------------------------------------
    // Expected outcome per condition select
    // ----------------------------------------------------------------
    logic [9:0] tv;
    logic iss, hit, swr, nv;
    assign nv = FLAGS[FLAG_N] ^ FLAGS[FLAG_V];
    assign tv = {FLAGS[FLAG_T], !FLAGS[FLAG_H], FLAGS[FLAG_H], nv, !nv, !FLAGS[FLAG_N],
        FLAGS[FLAG_N], FLAGS[FLAG_C], !FLAGS[FLAG_C], !FLAGS[FLAG_C]};
    // Selects above nine are never taken; the range test masks the x index
    assign hit = BR_COND <= 4'h9 && tv[BR_COND];
    assign iss = CE && BR_VALID && BR_READY;
    assign swr = AVS_WRITE && !AVS_WAITREQUEST;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Taken branch: busy first cycle, lands on the target in the second
    sequence s_busy;
        !BR_READY && BR_TAKEN && !BR_DONE;
    endsequence
    sequence s_land;
        BR_DONE && PC == PC_W'($past(PC, 2) + PC_W'(signed'($past(BR_OFFSET, 2))) + 1);
    endsequence
    a_nt_step: assert property (iss && !hit |=> BR_DONE && !BR_TAKEN
        && PC == PC_W'($past(PC) + 1)) else $error("not-taken step wrong");
    a_tk_path: assert property (iss && hit |=> s_busy ##1 s_land)
        else $error("taken path wrong");
    a_tk_ready: assert property (iss && hit |=> BR_TAKEN throughout (!BR_READY ##1 BR_READY))
        else $error("ready not back");
    a_done_cause: assert property (BR_DONE |-> $past(iss && !hit) || $past(iss && hit, 2))
        else $error("done without issue");
    a_outcome_flag: assert property (iss |=> BR_TAKEN == $past(hit))
        else $error("outcome wrong");
    a_flags_kept: assert property (!swr |=> $stable(FLAGS))
        else $error("flags changed");
    a_pc_quiet: assert property (!iss && BR_READY && !swr |=> $stable(PC))
        else $error("pc moved alone");
    a_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("wait state wrong");
endmodule // cbu_assertions

bind cbu_branch_unit cbu_assertions chk_u (.CLK, .RESET_N, .CE, .BR_VALID, .BR_COND,
    .BR_OFFSET, .BR_READY, .BR_DONE, .BR_TAKEN, .PC, .FLAGS, .AVS_READ, .AVS_WRITE,
    .AVS_WAITREQUEST);

// ---- dv/tb_top.sv ----
// Purpose: Directed bench for the conditional branch unit
// Assumes: CLK 20 MHz, reset low for 20 cycles
// Notes: Outcomes come from a local decode, not the design
`define CHK(nm, ex, got) compares++; if ((got) !== (ex)) begin num_errors++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end
module tb_top
    import cbu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, vld = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] cnd = 4'h0, adr = 4'h0, be = 4'hF;
    logic [6:0] ofs = 7'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic rdy, done, tkn, wq;
    logic [15:0] pc;
    logic [7:0] flg;
    int num_errors = 0;
    int compares = 0;
    int ntk = 0;
    logic ltk = 1'b0;
    // 20 MHz core clock
    always #25 clk = ~clk;
    cbu_branch_unit dut_u (.CLK(clk), .RESET_N(rst_n), .CE(ce), .BR_VALID(vld),
        .BR_COND(cnd), .BR_OFFSET(ofs), .BR_READY(rdy), .BR_DONE(done), .BR_TAKEN(tkn),
        .PC(pc), .FLAGS(flg), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq));
    task automatic conclude();
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic cexp(input logic [3:0] c, input logic [7:0] f);
        logic [9:0] t;
        logic x;
        x = f[FLAG_N] ^ f[FLAG_V];
        t = {f[FLAG_T], !f[FLAG_H], f[FLAG_H], x, !x, !f[FLAG_N], f[FLAG_N], f[FLAG_C],
            !f[FLAG_C], !f[FLAG_C]};
        return c <= 4'h9 && t[c];
    endfunction
    // Avalon access; the wait loop is bounded so a stuck slave ends the run
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= b;
        // Request stands until the rising edge that sees waitrequest low
        do begin
            @(posedge clk);
            if (++n > 20) begin num_errors++; conclude(); end
        end while (wq);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // One branch; outcome judged the cycle after issue, landing address after it completes
    task automatic br(input logic [3:0] c, input logic [6:0] k);
        logic [15:0] p0;
        logic [7:0] f0;
        logic t;
        int n;
        n = 0;
        @(posedge clk);
        vld <= 1'b1;
        cnd <= c;
        ofs <= k;
        @(negedge clk);
        while (!rdy) begin
            @(negedge clk);
            if (++n > 20) begin num_errors++; conclude(); end
        end
        p0 = pc;
        f0 = flg;
        t = cexp(c, f0);
        @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        `CHK("taken", t, tkn)
        `CHK("ready", !t, rdy)
        if (t) @(negedge clk);
        `CHK("done", 1'b1, done)
        `CHK("pc", 16'(p0 + (t ? {{9{k[6]}}, k} : 16'h0) + 16'h1), pc)
        `CHK("flags", f0, flg)
        if (t) ntk++;
        ltk = t;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        `CHK("pc", 16'h0000, pc)
        `CHK("flags", 8'h00, flg)
        av(1'b0, ADDR_CTRL, 32'h0, 4'hF);
        `CHK("ctrl", 1'b1, q[0])
    endtask
    // Selects 0 to 10 under four flag patterns, offsets at both extremes
    task automatic t_table();
        logic [7:0] fl [4] = '{8'h00, 8'h65, 8'h0C, 8'h08};
        foreach (fl[i]) begin
            av(1'b1, ADDR_FLAGS, {24'h0, fl[i]}, 4'hF);
            for (int c = 0; c < 11; c++) br(4'(c), c[0] ? 7'h40 : 7'h3F);
        end
    endtask
    // Not-taken every cycle, then two taken with the request held high
    task automatic t_b2b();
        logic [15:0] p0;
        av(1'b1, ADDR_FLAGS, 32'h1, 4'hF);
        @(posedge clk);
        vld <= 1'b1;
        cnd <= 4'h0;
        @(negedge clk);
        p0 = pc;
        repeat (3) @(posedge clk);
        cnd <= 4'h2;
        ofs <= 7'h05;
        @(negedge clk);
        `CHK("pc b2b", 16'(p0 + 16'h3), pc)
        repeat (3) @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        `CHK("pc held", 16'(p0 + 16'h9), pc)
        @(negedge clk);
        `CHK("pc second", 16'(p0 + 16'hF), pc)
        ntk += 2;
        ltk = 1'b1;
    endtask
    // Branches refused while disabled; status shows the taken count
    task automatic t_ctrl();
        logic [15:0] p0;
        av(1'b1, ADDR_CTRL, 32'h0, 4'hF);
        @(negedge clk);
        p0 = pc;
        `CHK("ready off", 1'b0, rdy)
        @(posedge clk);
        vld <= 1'b1;
        cnd <= 4'h2;
        repeat (3) @(posedge clk);
        vld <= 1'b0;
        @(negedge clk);
        `CHK("pc refused", p0, pc)
        `CHK("done refused", 1'b0, done)
        av(1'b1, ADDR_CTRL, 32'h1, 4'hF);
        av(1'b0, ADDR_STAT, 32'h0, 4'hF);
        `CHK("taken count", 16'(ntk), q[STAT_CNT_LSB +: 16])
        `CHK("last taken", ltk, q[STAT_TAKEN_BIT])
        `CHK("busy", 1'b0, q[STAT_BUSY_BIT])
    endtask
    // Byte enables, unmapped place and a frozen clock enable
    task automatic t_regs();
        av(1'b1, ADDR_PC, 32'hABCD, 4'hF);
        av(1'b1, ADDR_PC, 32'h1234, 4'h1);
        av(1'b0, ADDR_PC, 32'h0, 4'hF);
        `CHK("pc bytes", 16'hAB34, q[15:0])
        av(1'b0, 4'h2, 32'h0, 4'hF);
        `CHK("unmapped", 32'h0, q)
        @(posedge clk);
        ce <= 1'b0;
        vld <= 1'b1;
        repeat (3) @(posedge clk);
        vld <= 1'b0;
        ce <= 1'b1;
        @(negedge clk);
        `CHK("pc frozen", 16'hAB34, pc)
        // Reset again in mid-run: PC, ready and the status word must come back clean
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("pc reset", PC_RESET, pc)
        `CHK("ready reset", 1'b1, rdy)
        av(1'b0, ADDR_STAT, 32'h0, 4'hF);
        `CHK("stat reset", 32'h0, q)
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_table();
        t_b2b();
        t_ctrl();
        t_regs();
        conclude();
    end
endmodule // tb_top
